// *** error_alarm_monitor.sv ***
// Error event masking and alarm pin logic of the interpolator.
// Assumes event inputs and the configuration port are synchronous to
// core_clk; the pin level arrives asynchronously and is synchronised here.
//
// Overview of operation
// R1: Monitor inputs, interpolator and supply loop; one event per fault.
// R2: Three masks filter events: alarm pin, driver shutdown, EEPROM logging.
// R3: Alarm pin is open-drain pull-down plus switchable internal pull-up.
// R4: Alarm pin is also sensed so an outside party can report errors.
// R5: Polarity 0 pulls low on error; polarity 1 releases on error.
// R6: During driver shutdown the alarm pin is released and shows nothing.
// R7: Hold time code n holds the alarm n times 12.5 ms.
// R8: Pull-up enable bit switches the internal pull-up source on or off.
// R9: Alarm mask bit 1 lets that event move the pin; 0 ignores it. Here event 6 releases the pin whatever its mask bit.
// R10: Event 9 flags a wrong line count between two zero pulses.
// R11: Event 8 flags output angle lagging the input angle.
// R12: Event 7 flags input frequency too high for the engine.
// R13: Overspeed threshold depends only on the system clock rate.
// R14: Event 6 flags configuration error: checksum, no acknowledge, pin fault.
// R15: Configuration error cannot pull the pin low; use polarity 1.
// R16: Event 5 is overtemperature; event 4 is raw index when hold is 0.
// R17: Event 3 flags supply control loop at its maximum limit.
// R18: Event 2 flags supply control loop at its minimum limit.
// R19: Event 1 flags input signal clipping.
// R20: Event 0 flags loss of signal, amplitude or phase fault.
// R21: Outside party pulls line low at polarity 0; seen as event 4.
// R22: Alarm is OR of masked events, held for the minimum time.
// R23: Sensed pin passes two flip-flops before use.
module error_alarm_monitor
  import alarm_pkg::*;
#(
  parameter int unsigned HOLD_STEP = HOLD_STEP_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  input  wire logic       cfg_wr,
  output logic      [7:0] cfg_rdata,
  input  wire logic       signal_loss,
  input  wire logic       signal_clipping,
  input  wire logic       ctrl_min_limit,
  input  wire logic       ctrl_max_limit,
  input  wire logic       index_enable_raw,
  input  wire logic       overtemp_warning,
  input  wire logic       config_error,
  input  wire logic       input_overspeed,
  input  wire logic       output_lag,
  input  wire logic       line_count_error,
  input  wire logic       driver_shutdown,
  input  wire logic       alarm_pin_in,
  output logic            alarm_pin_out,
  output logic            alarm_pin_oe,
  output logic            alarm_pullup_on,
  output logic            ext_system_error,
  output logic            shutdown_request,
  output logic      [9:0] log_events
);

  logic [9:0] alarm_event_mask_reg;
  logic [9:0] shutdown_event_mask_reg;
  logic [9:0] logging_event_mask_reg;
  logic [2:0] alarm_min_hold_time_reg;
  logic       alarm_polarity_select_reg;
  logic       alarm_pullup_enable_reg;
  logic [7:0] pin_ctrl_spare_reg;

  logic       pin_meta_reg;
  logic       pin_sync_reg;
  logic [2:0] drive_hist_reg;
  logic       ext_error_reg;
  logic       alarm_pin_oe_reg;
  logic       shutdown_request_reg;
  logic [9:0] log_events_reg;
  logic [7:0] cfg_rdata_reg;

  logic [9:0] internal_events;
  logic [9:0] system_events;
  logic       pin_disabled;
  logic       drive_low;

  hold_if hold ();

  // Gathers the internal fault sources into one event vector.
  always_comb begin
    internal_events                 = '0;
    internal_events[EV_SIGNAL_LOSS] = signal_loss;      // R1 R20
    internal_events[EV_CLIPPING]    = signal_clipping;  // R19
    internal_events[EV_CTRL_MIN]    = ctrl_min_limit;   // R18
    internal_events[EV_CTRL_MAX]    = ctrl_max_limit;   // R17
    // The raw index comparator is visible only with no hold time, so it
    // can be used to adjust the zero pulse position without stretching.
    internal_events[EV_INDEX_EXT]   =
      index_enable_raw & (alarm_min_hold_time_reg == 3'h0); // R16
    internal_events[EV_OVERTEMP]    = overtemp_warning; // R16
    internal_events[EV_CONFIG]      = config_error;     // R14
    // The overspeed flag comes from the engine's capture limit, which is
    // set by the system clock alone, not by resolution or edge spacing.
    internal_events[EV_OVERSPEED]   = input_overspeed;  // R12 R13
    internal_events[EV_OUTPUT_LAG]  = output_lag;       // R11
    internal_events[EV_LINE_COUNT]  = line_count_error; // R10
  end

  // For shutdown and logging, event 4 stands for the external error.
  always_comb begin
    system_events               = internal_events;
    system_events[EV_INDEX_EXT] = ext_error_reg; // R21
  end

  // Merges one configuration byte into a 10-bit mask kept in two bytes.
  function automatic logic [9:0] mask_write(
    input logic [9:0] mask,
    input logic [7:0] addr,
    input logic [7:0] lo_addr,
    input logic [7:0] hi_addr,
    input logic [7:0] data
  );
    mask_write = mask;
    if (addr == lo_addr) begin
      mask_write[7:0] = data;
    end
    if (addr == hi_addr) begin
      mask_write[9:8] = data[MASK_HI_LSB +: 2];
    end
  endfunction

  // Configuration writes.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_event_mask_reg <= ALARM_MASK_RESET;
    end else if (cfg_wr) begin
      alarm_event_mask_reg <= mask_write(alarm_event_mask_reg, cfg_addr,
        ALARM_MASK_LO_ADDR, ALARM_MASK_HI_ADDR, cfg_wdata); // R9
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_min_hold_time_reg <= HOLD_TIME_RESET;
    end else if (cfg_wr && (cfg_addr == ALARM_MASK_HI_ADDR)) begin
      alarm_min_hold_time_reg <= cfg_wdata[HOLD_TIME_LSB +: 3]; // R7
    end
  end

  // The top bits of the shutdown mask share the pin control byte.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shutdown_event_mask_reg <= SHUTDOWN_MASK_RESET;
    end else if (cfg_wr) begin
      shutdown_event_mask_reg <= mask_write(shutdown_event_mask_reg,
        cfg_addr, SHUTDOWN_MASK_LO_ADDR, PIN_CTRL_ADDR, cfg_wdata); // R2
    end
  end

  // Polarity and pull-up take effect at the edge of the write.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_polarity_select_reg <= POLARITY_RESET;
    end else if (cfg_wr && (cfg_addr == PIN_CTRL_ADDR)) begin
      alarm_polarity_select_reg <= cfg_wdata[POLARITY_BIT]; // R5
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_pullup_enable_reg <= PULLUP_RESET;
    end else if (cfg_wr && (cfg_addr == PIN_CTRL_ADDR)) begin
      alarm_pullup_enable_reg <= cfg_wdata[PULLUP_BIT]; // R8
    end
  end

  // Bits owned by neighbouring blocks are kept for read-back only.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_ctrl_spare_reg <= 8'h00;
    end else if (cfg_wr && (cfg_addr == PIN_CTRL_ADDR)) begin
      pin_ctrl_spare_reg <= cfg_wdata & 8'hCC;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      logging_event_mask_reg <= LOGGING_MASK_RESET;
    end else if (cfg_wr) begin
      logging_event_mask_reg <= mask_write(logging_event_mask_reg,
        cfg_addr, LOGGING_MASK_LO_ADDR, LOGGING_MASK_HI_ADDR,
        cfg_wdata); // R2
    end
  end

  // Read data follows the address one cycle later; unmapped reads zero.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_rdata_reg <= 8'h00;
    end else begin
      unique case (cfg_addr)
        ALARM_MASK_LO_ADDR: cfg_rdata_reg <= alarm_event_mask_reg[7:0];
        ALARM_MASK_HI_ADDR: cfg_rdata_reg <= {1'b0,
          alarm_min_hold_time_reg, 2'b00, alarm_event_mask_reg[9:8]};
        SHUTDOWN_MASK_LO_ADDR:
          cfg_rdata_reg <= shutdown_event_mask_reg[7:0];
        PIN_CTRL_ADDR: cfg_rdata_reg <= pin_ctrl_spare_reg |
          {2'b00, alarm_pullup_enable_reg, alarm_polarity_select_reg,
           2'b00, shutdown_event_mask_reg[9:8]};
        LOGGING_MASK_LO_ADDR:
          cfg_rdata_reg <= logging_event_mask_reg[7:0];
        LOGGING_MASK_HI_ADDR:
          cfg_rdata_reg <= {6'h00, logging_event_mask_reg[9:8]};
        ALARM_STATUS_ADDR: cfg_rdata_reg <= {4'h0, pin_disabled,
          pin_sync_reg, ext_error_reg, hold.alarm_held};
        default: cfg_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign cfg_rdata = cfg_rdata_reg;

  // Alarm condition and its minimum indication time.
  assign hold.alarm_raw = |(internal_events & alarm_event_mask_reg); // R9 R22
  assign hold.hold_code = alarm_min_hold_time_reg; // R7

  alarm_hold_timer #(
    .STEP_CYCLES (HOLD_STEP)
  ) u_hold (
    .core_clk (core_clk),
    .reset    (reset),
    .hold     (hold.timer)
  );

  // A configuration error always releases the pin, as a driver shutdown does, so the pin can
  // only report it by being released with polarity 1.
  assign pin_disabled = driver_shutdown | config_error; // R6 R15

  assign drive_low = alarm_polarity_select_reg ?
                     ~hold.alarm_held : hold.alarm_held; // R5

  // Open-drain driver: the output level is always low, only the enable
  // moves.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alarm_pin_oe_reg <= 1'b0;
    end else begin
      alarm_pin_oe_reg <= drive_low & ~pin_disabled; // R3 R5 R6
    end
  end

  assign alarm_pin_out = 1'b0; // R3
  assign alarm_pin_oe = alarm_pin_oe_reg;
  assign alarm_pullup_on = alarm_pullup_enable_reg; // R8

  // Pin sense synchroniser.
  // Both stages reset to the idle high level, so no false low follows.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= alarm_pin_in; // R23
      pin_sync_reg <= pin_meta_reg; // R23
    end
  end

  // Remembers whether our pull-down was on in each of the last three cycles.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      drive_hist_reg <= 3'h0;
    end else begin
      drive_hist_reg <= {drive_hist_reg[1:0], alarm_pin_oe_reg};
    end
  end

  // Our own pull-down takes three cycles to leave the synchroniser, so a
  // low is blamed on the outside only when we have not driven lately.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_error_reg <= 1'b0;
    end else begin
      ext_error_reg <= ~alarm_polarity_select_reg & ~pin_sync_reg &
                       ~alarm_pin_oe_reg & (drive_hist_reg == 3'h0); // R4 R5
    end
  end

  assign ext_system_error = ext_error_reg;

  // Shutdown and logging filters.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shutdown_request_reg <= 1'b0;
    end else begin
      shutdown_request_reg <= |(system_events & shutdown_event_mask_reg); // R2
    end
  end

  // Logging sees the same events as shutdown, through its own mask.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      log_events_reg <= '0;
    end else begin
      log_events_reg <= system_events & logging_event_mask_reg; // R2
    end
  end

  assign shutdown_request = shutdown_request_reg;
  assign log_events = log_events_reg;

endmodule

// *** alarm_pkg.sv ***
// Constants shared by the alarm monitor and its indication-time timer.
// Assumes one 100 MHz system clock and a byte-wide configuration port.
package alarm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HOLD_STEP_US = 12500;
  localparam int unsigned HOLD_STEP_CYCLES =
    (HOLD_STEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CNT_W = 24;

  localparam int unsigned EVENT_W = 10;

  // Register byte addresses.
  localparam logic [7:0] ALARM_MASK_LO_ADDR    = 8'h17;
  localparam logic [7:0] ALARM_MASK_HI_ADDR    = 8'h18;
  localparam logic [7:0] SHUTDOWN_MASK_LO_ADDR = 8'h19;
  localparam logic [7:0] PIN_CTRL_ADDR         = 8'h1A;
  localparam logic [7:0] LOGGING_MASK_LO_ADDR  = 8'h1B;
  localparam logic [7:0] LOGGING_MASK_HI_ADDR  = 8'h1C;
  localparam logic [7:0] ALARM_STATUS_ADDR     = 8'h3E;

  // Field positions.
  localparam int unsigned HOLD_TIME_LSB    = 4;
  localparam int unsigned POLARITY_BIT     = 4;
  localparam int unsigned PULLUP_BIT       = 5;
  localparam int unsigned MASK_HI_LSB      = 0;
  localparam int unsigned STAT_ALARM_BIT   = 0;
  localparam int unsigned STAT_EXT_BIT     = 1;
  localparam int unsigned STAT_PIN_BIT     = 2;
  localparam int unsigned STAT_DISABLE_BIT = 3;

  // Event bit positions.
  localparam int unsigned EV_SIGNAL_LOSS = 0;
  localparam int unsigned EV_CLIPPING    = 1;
  localparam int unsigned EV_CTRL_MIN    = 2;
  localparam int unsigned EV_CTRL_MAX    = 3;
  localparam int unsigned EV_INDEX_EXT   = 4;
  localparam int unsigned EV_OVERTEMP    = 5;
  localparam int unsigned EV_CONFIG      = 6;
  localparam int unsigned EV_OVERSPEED   = 7;
  localparam int unsigned EV_OUTPUT_LAG  = 8;
  localparam int unsigned EV_LINE_COUNT  = 9;

  // Reset values.
  localparam logic [9:0] ALARM_MASK_RESET    = 10'h000;
  localparam logic [9:0] SHUTDOWN_MASK_RESET = 10'h000;
  localparam logic [9:0] LOGGING_MASK_RESET  = 10'h000;
  localparam logic [2:0] HOLD_TIME_RESET     = 3'h0;
  localparam logic       POLARITY_RESET      = 1'b0;
  localparam logic       PULLUP_RESET        = 1'b1;

endpackage

// *** hold_if.sv ***
// Carrier between the alarm monitor and its indication-time timer.
// Assumes both ends share core_clk.
interface hold_if;
  logic       alarm_raw;
  logic [2:0] hold_code;
  logic       alarm_held;

  modport owner (output alarm_raw, output hold_code, input alarm_held);
  modport timer (input alarm_raw, input hold_code, output alarm_held);
endinterface

// *** alarm_hold_timer.sv ***
// Stretches the raw alarm so it stands at least code times one step.
// Assumes the raw alarm is already synchronous to core_clk.
module alarm_hold_timer
  import alarm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = HOLD_STEP_CYCLES
) (
  input  wire logic    core_clk,
  input  wire logic    reset,
  hold_if.timer        hold
);

  logic [HOLD_CNT_W-1:0] remain_reg;
  logic [HOLD_CNT_W-1:0] load_value;

  function automatic logic [HOLD_CNT_W-1:0] hold_cycles(
    input logic [2:0] code
  );
    hold_cycles = HOLD_CNT_W'(code) * HOLD_CNT_W'(STEP_CYCLES);
  endfunction

  assign load_value = hold_cycles(hold.hold_code);

  // The count restarts on every cycle the raw alarm stands, so the hold
  // is measured from the end of the condition.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      remain_reg <= '0;
    end else if (hold.alarm_raw) begin
      remain_reg <= load_value; // R22
    end else if (remain_reg != '0) begin
      remain_reg <= remain_reg - HOLD_CNT_W'(1);
    end
  end

  assign hold.alarm_held = hold.alarm_raw | (remain_reg != '0); // R7 R22

endmodule

// *** error_alarm_monitor_chk.sv ***
// Concurrent checks on the alarm monitor's top-level ports.
// Assumes one clock domain and the synchronous active-high reset.
module error_alarm_monitor_chk (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic       cfg_wr,
  input wire logic [7:0] cfg_rdata,
  input wire logic       config_error,
  input wire logic       driver_shutdown,
  input wire logic       alarm_pin_in,
  input wire logic       alarm_pin_oe,
  input wire logic       alarm_pullup_on,
  input wire logic       ext_system_error,
  input wire logic       shutdown_request,
  input wire logic [9:0] log_events
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_shutdown_quiet: assert property (
    driver_shutdown |=> !alarm_pin_oe) else $error("pin driven in shutdown");
  chk_cfg_err_quiet: assert property (
    config_error |=> !alarm_pin_oe) else $error("pin low on config error");
  chk_ext_synced: assert property (
    $rose(ext_system_error) |-> !$past(alarm_pin_in, 3)
      && !$past(reset, 3)) else $error("ext error before sync");
  chk_ext_idle_pin: assert property (
    $rose(ext_system_error) |-> !$past(alarm_pin_oe, 1)
      && !$past(alarm_pin_oe, 3)) else $error("ext error from own pull");
  chk_rdata_echo: assert property (
    (cfg_wr && cfg_addr inside {8'h17, 8'h19, 8'h1A, 8'h1B})
      ##1 (!cfg_wr && $stable(cfg_addr))
      |=> cfg_rdata == $past(cfg_wdata, 2)) else $error("read-back wrong");
  chk_pullup_follow: assert property (
    (cfg_wr && cfg_addr == 8'h1A) ##1 !(cfg_wr && cfg_addr == 8'h1A)
      ##1 !(cfg_wr && cfg_addr == 8'h1A)
      |=> alarm_pullup_on == $past(cfg_wdata[5], 3))
    else $error("pull-up not following bit");
  chk_reset_values: assert property (
    $fell(reset) |-> !alarm_pin_oe && alarm_pullup_on && !ext_system_error
      && !shutdown_request && log_events == 10'h000
      && cfg_rdata == 8'h00) else $error("reset values wrong");
  chk_sd_quiet: assert property (
    $fell(reset) |-> !shutdown_request [*3]) else $error("early shutdown");
endmodule

bind error_alarm_monitor error_alarm_monitor_chk chk_inst (
  .core_clk(core_clk), .reset(reset), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata),
  .config_error(config_error), .driver_shutdown(driver_shutdown),
  .alarm_pin_in(alarm_pin_in), .alarm_pin_oe(alarm_pin_oe),
  .alarm_pullup_on(alarm_pullup_on), .ext_system_error(ext_system_error),
  .shutdown_request(shutdown_request), .log_events(log_events));

// *** alarm_line_model.sv ***
// Far end of the shared open-drain alarm line: another party may pull it.
// Assumes a board pull-up keeps the line high while nobody pulls.
module alarm_line_model (
  input  wire logic dut_out,
  input  wire logic dut_oe,
  input  wire logic ext_pull_low,
  output logic      line_level
);
  timeunit 1ns;
  timeprecision 1ps;
  assign line_level = (dut_oe ? dut_out : 1'b1) & !ext_pull_low;
endmodule

// *** testbench.sv ***
// Self-checking bench for the alarm monitor and its line partner.
// Assumes the design files, checker and line model compile first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 10;
  logic       core_clk = 0, reset = 1, cfg_wr = 0, drv_off = 0, pull = 0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00;
  logic [9:0] ev = 10'h000;
  wire  [7:0] rdata;
  wire  [9:0] log_ev;
  wire        pin, p_out, oe, pu, ext, sd;
  int         errors = 0, n_compared = 0;
  always #5 core_clk = ~core_clk;
  error_alarm_monitor #(.HOLD_STEP(STEP)) error_alarm_monitor_inst (
    .core_clk(core_clk), .reset(reset), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rdata(rdata),
    .signal_loss(ev[0]), .signal_clipping(ev[1]), .ctrl_min_limit(ev[2]),
    .ctrl_max_limit(ev[3]), .index_enable_raw(ev[4]),
    .overtemp_warning(ev[5]), .config_error(ev[6]),
    .input_overspeed(ev[7]), .output_lag(ev[8]), .line_count_error(ev[9]),
    .driver_shutdown(drv_off), .alarm_pin_in(pin), .alarm_pin_out(p_out),
    .alarm_pin_oe(oe), .alarm_pullup_on(pu), .ext_system_error(ext),
    .shutdown_request(sd), .log_events(log_ev));
  alarm_line_model alarm_line_model_inst (.dut_out(p_out), .dut_oe(oe),
    .ext_pull_low(pull), .line_level(pin));
  task automatic cmp_bit(string nm, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_vec(string nm, logic [9:0] e, logic [9:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1;
    @(negedge core_clk);
    cfg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge core_clk);
    cfg_addr = a;
    @(negedge core_clk);
    cmp_vec("cfg_rdata", {2'b00, e}, {2'b00, rdata});
  endtask
  task automatic test_reset();
    logic [7:0] a[7] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h40};
    foreach (a[i]) rd(a[i], (a[i] == 8'h1A) ? 8'h20 : 8'h00);
    rd(8'h3E, 8'h04);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    $display("test reset done");
  endtask
  task automatic test_events();
    logic [7:0] d[6] = '{8'hFF, 8'h03, 8'hFF, 8'h23, 8'hFF, 8'h03};
    foreach (d[i]) wr(8'h17 + 8'(i), d[i]);
    rd(8'h17, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      ev = 10'h001 << i;
      tick(2);
      cmp_bit("alarm_pin_oe", i != 6, oe);
      cmp_bit("shutdown_request", i != 4, sd);
      cmp_vec("log_events", (i == 4) ? 10'h000 : ev, log_ev);
      ev = 10'h000;
      tick(2);
      cmp_bit("alarm_pin_oe", 1'b0, oe);
      tick(2);
    end
    $display("test events done");
  endtask
  task automatic test_hold();
    wr(8'h18, 8'h23);
    ev[0] = 1;
    tick(2);
    ev[0] = 0;
    tick(2 * STEP - 5);
    cmp_bit("alarm_pin_oe", 1'b1, oe);
    tick(10);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    ev[4] = 1;
    tick(2);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    cmp_vec("log_events", 10'h000, log_ev);
    ev[4] = 0;
    wr(8'h18, 8'h03);
    tick(3);
    $display("test hold done");
  endtask
  task automatic test_polarity();
    wr(8'h1A, 8'h33);
    tick(2);
    cmp_bit("alarm_pin_oe", 1'b1, oe);
    cmp_bit("alarm_pin_out", 1'b0, p_out);
    ev[0] = 1;
    tick(2);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    ev = 10'h040;
    tick(2);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    ev = 10'h000;
    drv_off = 1;
    tick(2);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    wr(8'h1A, 8'h23);
    ev[0] = 1;
    tick(2);
    cmp_bit("alarm_pin_oe", 1'b0, oe);
    ev[0] = 0;
    drv_off = 0;
    tick(3);
    $display("test polarity done");
  endtask
  task automatic test_pullup();
    wr(8'h1A, 8'h03);
    tick(2);
    cmp_bit("alarm_pullup_on", 1'b0, pu);
    rd(8'h1A, 8'h03);
    wr(8'h1A, 8'h23);
    tick(2);
    cmp_bit("alarm_pullup_on", 1'b1, pu);
    $display("test pullup done");
  endtask
  task automatic test_ext();
    pull = 1;
    tick(2);
    cmp_bit("ext_system_error", 1'b0, ext);
    tick(3);
    cmp_bit("ext_system_error", 1'b1, ext);
    cmp_bit("shutdown_request", 1'b1, sd);
    cmp_vec("log_events", 10'h010, log_ev);
    pull = 0;
    tick(6);
    cmp_bit("ext_system_error", 1'b0, ext);
    $display("test ext done");
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    tick(16);
    reset = 0;
    test_reset();
    test_events();
    test_hold();
    test_polarity();
    test_pullup();
    test_ext();
    print_verdict();
  end
endmodule
